/* src/dws_pkg.sv */
/*
  Shared constants for the disk write serializer: register map, field
  positions, reset values, cell timing and check polynomials.
  Assumes a 40 MHz system clock.
*/
package dws_pkg;
  // Register indices on the plain register port.
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_MASK   = 2'h1;
  localparam logic [1:0] ADDR_CTRL   = 2'h2;
  // Status and mask bit positions.
  localparam int ST_BYTE   = 0;
  localparam int ST_UNLOAD = 1;
  localparam int ST_SEED   = 2;
  localparam int ST_LIVE   = 4;
  localparam int EV_W      = 3;
  // Control bit positions and reset value.
  localparam int CT_ECC  = 0;
  localparam int CT_SLOW = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;
  // Pin synchroniser layout.
  localparam int SYNC_W  = 16;
  localparam int SY_DATA = 0;
  localparam int SY_STB  = 8;
  localparam int SY_WEN  = 9;
  localparam int SY_INIT = 10;
  localparam int SY_LA   = 11;
  localparam int SY_PC   = 12;
  localparam int SY_TAP  = 13;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 16'h0e00;
  // Cell timing: half of one write-clock period.
  localparam int CLK_PERIOD_NS = 25;
  localparam int CELL_FAST_NS  = 100;
  localparam int CELL_SLOW_NS  = 115;
  localparam int BYTE_FAST_NS  = 1600;
  localparam int BYTE_SLOW_NS  = 1840;
  localparam logic [2:0] CELL_FAST_CYC =
    3'((CELL_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] CELL_SLOW_CYC =
    3'((CELL_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] LAST_BIT = 3'h7;
  // Check polynomials; register preset is all ones.
  localparam logic [31:0] ECC_MASK = 32'h140a0445;
  localparam logic [31:0] CRC_MASK = 32'h00001021;
  localparam logic [31:0] CRC_KEEP = 32'h0000ffff;
  localparam logic [31:0] CHK_PRESET = 32'hffffffff;
  // Precompensation select order {early, nominal, late}.
  localparam logic [2:0] SEL_EARLY = 3'h4;
  localparam logic [2:0] SEL_NOM   = 3'h2;
  localparam logic [2:0] SEL_LATE  = 3'h1;
endpackage

/* src/dws_check_gen.sv */
/*
  Check-bit generator: passes serial data through while dividing it by
  the CRC or ECC polynomial, then unloads the remainder.
  Assumes bit_tick is a one-cycle pulse per bit and inputs are synchronous.
*/
`timescale 1ns/100ps
module dws_check_gen
  import dws_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic bit_tick,
  input  wire logic init_n,
  input  wire logic ecc_mode,
  input  wire logic unload,
  input  wire logic data_in,
  output logic      check_out,
  output logic      seed_pulse
);
  typedef struct packed {
    logic [31:0] rem;
    logic        armed;
    logic        out;
    logic        seed;
  } dws_chk_s;

  dws_chk_s st_reg;
  dws_chk_s st_next;

  // One division step; CRC mode keeps only the low sixteen bits.
  function automatic logic [31:0] dws_step(input logic [31:0] r, input logic b, input logic ecc);
    logic        fb;
    logic [31:0] n;
    fb = b ^ (ecc ? r[31] : r[15]);
    n  = {r[30:0], 1'b0} ^ (fb ? (ecc ? ECC_MASK : CRC_MASK) : 32'h0);
    return ecc ? n : (n & CRC_KEEP);
  endfunction

  // Data pass, arming latch and unloading.
  always_comb begin
    st_next      = st_reg;
    st_next.seed = 1'b0;
    if (bit_tick) begin
      st_next.out = data_in;
      if (!init_n) begin
        st_next.rem   = CHK_PRESET;
        st_next.armed = 1'b1;
      end else if (unload) begin
        st_next.out   = ecc_mode ? st_reg.rem[31] : st_reg.rem[15];
        st_next.rem   = ecc_mode ? {st_reg.rem[30:0], 1'b0} : ({st_reg.rem[30:0], 1'b0} & CRC_KEEP);
        st_next.armed = 1'b0;
      end else if (!st_reg.armed || data_in) begin
        st_next.rem   = dws_step(st_reg.rem, data_in, ecc_mode);
        st_next.armed = 1'b0;
        st_next.seed  = st_reg.armed;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{rem: CHK_PRESET, armed: 1'b1, out: 1'b0, seed: 1'b0};
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign check_out  = st_reg.out;
  assign seed_pulse = st_reg.seed;
endmodule

/* src/dws_mfm_enc.sv */
/*
  MFM encoder with write precompensation and delay-tap selection.
  Assumes edge pulses mark the start of the clock cell (rise) and data cell (fall).
*/
`timescale 1ns/100ps
module dws_mfm_enc
  import dws_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       edge_rise,
  input  wire logic       edge_fall,
  input  wire logic       data_in,
  input  wire logic       precomp_en,
  input  wire logic [2:0] taps,
  output logic            write_out,
  output logic [2:0]      sel_out,
  output logic            tap_out
);
  typedef struct packed {
    logic [3:0] win;
    logic       pulse;
    logic [2:0] sel;
    logic       tap;
  } dws_enc_s;

  dws_enc_s st_reg;
  dws_enc_s st_next;

  // Window is {next2, next1, present, previous}; unknown patterns stay nominal.
  function automatic logic [2:0] dws_pc(input logic [3:0] w, input logic is_data);
    logic [2:0] s;
    s = SEL_NOM;
    if (is_data) begin
      if (!w[0] && w[2]) s = SEL_EARLY;
      else if (w[0] && !w[2]) s = SEL_LATE;
    end else begin
      if (!w[2] && w[3]) s = SEL_EARLY;
      else if (w[2] && !w[3]) s = SEL_LATE;
    end
    return s;
  endfunction

  always_comb begin
    logic [3:0] w;
    w             = {data_in, st_reg.win[3:1]};
    st_next       = st_reg;
    st_next.pulse = 1'b0;
    if (edge_rise) begin
      st_next.win = w;
      if (!w[1] && !w[0]) begin
        st_next.pulse = 1'b1;
        st_next.sel   = dws_pc(w, 1'b0);
      end
    end else if (edge_fall && st_reg.win[1]) begin
      st_next.pulse = 1'b1;
      st_next.sel   = dws_pc(st_reg.win, 1'b1);
    end
    if (!precomp_en) st_next.sel = SEL_NOM;
    st_next.tap = |(st_reg.sel & {taps[0], taps[1], taps[2]});
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{win: 4'h0, pulse: 1'b0, sel: SEL_NOM, tap: 1'b0};
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign write_out = st_reg.pulse;
  assign sel_out   = st_reg.sel;
  assign tap_out   = st_reg.tap;
endmodule

/* src/dws_top.sv */
/*
  Write-side serial path of a disk controller: byte latch and serializer,
  check-bit generator, MFM encoder with precompensation, and a small
  register port with a level interrupt.
  Assumes processor pins are asynchronous and pass two flip-flops; the
  register port shares the 40 MHz clock; the delay line is external.
*/
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps

module dws_top
  import dws_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       clk_en,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] io_data,
  input  wire logic       byte_load_strobe,
  input  wire logic       write_enable_n,
  input  wire logic       check_init_n,
  input  wire logic       check_append_lookahead_n,
  input  wire logic       precomp_enable,
  input  wire logic       delay_tap1,
  input  wire logic       delay_tap2,
  input  wire logic       delay_tap3,
  output logic            write_clock,
  output logic            nrz_data,
  output logic            byte_slot_flag,
  output logic            byte_time_sync,
  output logic            encoded_write_out,
  output logic            precomp_early,
  output logic            precomp_nominal,
  output logic            precomp_late,
  output logic            precomp_write_out,
  output logic            irq
);
  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic              stb_d;
    logic [7:0]        cap;
    logic [7:0]        hold;
    logic [7:0]        shift;
    logic [2:0]        bit_cnt;
    logic [2:0]        cell_cnt;
    logic              wclk;
    logic              rise;
    logic              fall;
    logic              flag;
    logic              bsync;
    logic              unload;
    logic              la_pend;
    logic [1:0]        ctrl;
    logic [EV_W-1:0]   mask;
    logic [EV_W-1:0]   status;
    logic [7:0]        rdata;
    logic              irq;
  } dws_top_s;

  dws_top_s   st_reg;
  dws_top_s   st_next;
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  logic       chk_bit;
  logic       seed_pulse;
  logic       enc_pulse;
  logic [2:0] enc_sel;
  logic       enc_tap;

  // Assert at once, release through two flops so no flop sees a runt release.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // Event bits for the status register; the set always wins over a clear.
  function automatic logic [EV_W-1:0] dws_sticky(
    input logic [EV_W-1:0] cur,
    input logic [EV_W-1:0] set,
    input logic [EV_W-1:0] clr
  );
    return (cur & ~clr) | set;
  endfunction

  always_comb begin
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] clr;
    logic [2:0]      cell_last;
    logic            enabled;
    logic            stb;
    logic            load_done;
    logic            set_flag;
    ev        = '0;
    clr       = '0;
    st_next   = st_reg;

    // Pin synchronisers: the first stage feeds only the second.
    st_next.s1 = {delay_tap3, delay_tap2, delay_tap1, precomp_enable,
                  check_append_lookahead_n, check_init_n, write_enable_n,
                  byte_load_strobe, io_data};
    st_next.s2 = st_reg.s1;

    enabled   = !st_reg.s2[SY_WEN];
    stb       = st_reg.s2[SY_STB];
    cell_last = st_reg.ctrl[CT_SLOW] ? CELL_SLOW_CYC : CELL_FAST_CYC;

    // Byte capture. Data is synchronised beside the strobe, so the last
    // sample taken while the strobe is high is the byte to keep.
    st_next.stb_d = stb;
    if (stb) begin
      st_next.cap = st_reg.s2[SY_DATA +: 8];
    end
    load_done = st_reg.stb_d && !stb;
    if (load_done) begin
      st_next.hold = st_reg.cap;
    end

    // Write clock from the system clock; cell length by drive type.
    // byte of eight bits
    st_next.rise = 1'b0;
    st_next.fall = 1'b0;
    if (st_reg.cell_cnt == cell_last - 3'h1) begin
      st_next.cell_cnt = 3'h0;
      st_next.wclk     = !st_reg.wclk;
      st_next.rise     = !st_reg.wclk;
      st_next.fall     = st_reg.wclk;
    end else begin
      st_next.cell_cnt = st_reg.cell_cnt + 3'h1;
    end

    // Serializer, advanced at the start of each clock cell.
    set_flag      = 1'b0;
    st_next.bsync = 1'b0;
    if (!enabled) begin
      st_next.shift   = 8'h00;
      st_next.bit_cnt = LAST_BIT;
      st_next.unload  = 1'b0;
      st_next.la_pend = 1'b0;
    end else if (st_reg.rise) begin
      st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
      if (st_reg.bit_cnt == LAST_BIT) begin
        st_next.shift = st_reg.hold;
        set_flag      = 1'b1;
        st_next.bsync = 1'b1;
        // switch at boundary
        // The look-ahead seen here still lets the byte just moved into the
        // shifter go out; the switch takes effect one byte boundary later.
        st_next.unload  = st_reg.la_pend;
        st_next.la_pend = !st_reg.s2[SY_LA];
      end else begin
        st_next.shift = {st_reg.shift[6:0], 1'b0};
      end
    end

    if (set_flag) begin
      st_next.flag = 1'b1;
    end else if (load_done) begin
      st_next.flag = 1'b0;
    end

    // Events for the interrupt.
    ev[ST_BYTE]   = set_flag;
    ev[ST_UNLOAD] = st_next.unload && !st_reg.unload;
    ev[ST_SEED]   = seed_pulse;

    // Register writes; status bits clear by writing one.
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_STATUS: clr = reg_wdata[EV_W-1:0];
        ADDR_MASK:   st_next.mask = reg_wdata[EV_W-1:0];
        ADDR_CTRL:   st_next.ctrl = reg_wdata[1:0];
        default:     clr = '0;
      endcase
    end
    st_next.status = dws_sticky(st_reg.status, ev, clr);
    st_next.irq    = |(st_next.status & st_next.mask);

    // Read data stands for the one cycle after the strobe; unmapped reads zero.
    st_next.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_STATUS: st_next.rdata = {3'h0, st_reg.flag, 1'b0, st_reg.status};
        ADDR_MASK:   st_next.rdata = {5'h00, st_reg.mask};
        ADDR_CTRL:   st_next.rdata = {6'h00, st_reg.ctrl};
        default:     st_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{
        s1: SYNC_RESET,
        s2: SYNC_RESET,
        stb_d: 1'b0,
        cap: 8'h00,
        hold: 8'h00,
        shift: 8'h00,
        bit_cnt: LAST_BIT,
        cell_cnt: 3'h0,
        wclk: 1'b0,
        rise: 1'b0,
        fall: 1'b0,
        flag: 1'b0,
        bsync: 1'b0,
        unload: 1'b0,
        la_pend: 1'b0,
        ctrl: CTRL_RESET,
        mask: MASK_RESET,
        status: 3'h0,
        rdata: 8'h00,
        irq: 1'b0
      };
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // Check generator sees the serializer bit one bit time later.
  // append after data
  dws_check_gen u_check (
    .clock      (clock),
    .rst_n      (rst_n),
    .clk_en     (clk_en),
    .bit_tick   (st_reg.rise),
    .init_n     (st_reg.s2[SY_INIT]),
    .ecc_mode   (st_reg.ctrl[CT_ECC]),
    .unload     (st_reg.unload),
    .data_in    (st_reg.shift[7] & !st_reg.s2[SY_WEN]),
    .check_out  (chk_bit),
    .seed_pulse (seed_pulse)
  );

  // Encoder reads the generator output through a two-bit look-ahead window.
  dws_mfm_enc u_enc (
    .clock      (clock),
    .rst_n      (rst_n),
    .clk_en     (clk_en),
    .edge_rise  (st_reg.rise),
    .edge_fall  (st_reg.fall),
    .data_in    (chk_bit),
    .precomp_en (st_reg.s2[SY_PC]),
    .taps       (st_reg.s2[SY_TAP +: 3]),
    .write_out  (enc_pulse),
    .sel_out    (enc_sel),
    .tap_out    (enc_tap)
  );

  // Outputs come straight from flops here or in the submodules.
  assign reg_rdata         = st_reg.rdata;
  assign write_clock       = st_reg.wclk;
  assign nrz_data          = chk_bit;
  assign byte_slot_flag    = st_reg.flag;
  assign byte_time_sync    = st_reg.bsync;
  assign encoded_write_out = enc_pulse;
  assign precomp_early     = enc_sel[2];
  assign precomp_nominal   = enc_sel[1];
  assign precomp_late      = enc_sel[0];
  assign precomp_write_out = enc_tap;
  assign irq               = st_reg.irq;
endmodule

/* sim/dws_top_asserts.sv */
/*
  Checker for the write serializer top: byte pacing, pulse timing and
  precompensation selection.
  Assumes the delay taps echo the encoded pulse and clk_en stays high.
*/
`timescale 1ns/100ps
module dws_top_asserts
  import dws_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic [1:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       byte_load_strobe,
  input wire logic       write_enable_n,
  input wire logic       precomp_enable,
  input wire logic       delay_tap1,
  input wire logic       delay_tap2,
  input wire logic       delay_tap3,
  input wire logic       write_clock,
  input wire logic       nrz_data,
  input wire logic       byte_slot_flag,
  input wire logic       byte_time_sync,
  input wire logic       encoded_write_out,
  input wire logic       precomp_early,
  input wire logic       precomp_nominal,
  input wire logic       precomp_late,
  input wire logic       precomp_write_out
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  logic [6:0] gap_reg;
  logic       run_reg;
  logic [1:0] wc_reg;

  // Byte gap counter; trusted only while enable and speed stay put.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gap_reg <= 7'h00;
      run_reg <= 1'b0;
      wc_reg  <= 2'h0;
    end else begin
      gap_reg <= byte_time_sync ? 7'h00 : gap_reg + 7'h01;
      run_reg <= (byte_time_sync | run_reg) & ~write_enable_n & ~(reg_wr & (reg_addr == ADDR_CTRL));
      wc_reg  <= {wc_reg[0], write_clock};
    end
  end

  // The shortest legal pulse spacing is one write clock period.
  sequence s_quiet_gap;
    !encoded_write_out [*7];
  endsequence
  sequence s_off_long;
    write_enable_n [*8];
  endsequence

  a_pulse_gap: assert property (encoded_write_out |=> s_quiet_gap)
    else $error("encoded pulses closer than one period");
  a_cell_edge: assert property (encoded_write_out |-> write_clock != wc_reg[1])
    else $error("encoded pulse away from a cell start");
  a_byte_period: assert property (byte_time_sync && run_reg |-> gap_reg == 7'h3f || gap_reg == 7'h4f)
    else $error("byte boundary spacing wrong");
  a_flag_at_sync: assert property (byte_time_sync |-> byte_slot_flag)
    else $error("byte flag not set at boundary");
  a_load_clear: assert property ($fell(byte_load_strobe) |-> ##[3:5] (!byte_slot_flag || byte_time_sync))
    else $error("load did not clear byte flag");
  a_quiet_off: assert property (s_off_long ##1 s_off_long |-> !nrz_data && !byte_time_sync)
    else $error("serializer active while disabled");
  a_sel_onehot: assert property ($onehot({precomp_early, precomp_nominal, precomp_late}))
    else $error("precomp selection not one-hot");
  a_nominal_held: assert property (!precomp_enable [*8] |-> precomp_nominal)
    else $error("nominal not held with precomp off");
  a_tap_quiet: assert property (!(delay_tap1 || delay_tap2 || delay_tap3) [*5] |-> !precomp_write_out)
    else $error("write pulse without a tap pulse");
endmodule

bind dws_top dws_top_asserts i_chk (
  .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .byte_load_strobe(byte_load_strobe), .write_enable_n(write_enable_n),
  .precomp_enable(precomp_enable), .delay_tap1(delay_tap1), .delay_tap2(delay_tap2),
  .delay_tap3(delay_tap3), .write_clock(write_clock), .nrz_data(nrz_data),
  .byte_slot_flag(byte_slot_flag), .byte_time_sync(byte_time_sync),
  .encoded_write_out(encoded_write_out), .precomp_early(precomp_early),
  .precomp_nominal(precomp_nominal), .precomp_late(precomp_late),
  .precomp_write_out(precomp_write_out)
);

/* sim/dws_drive_model.sv */
/*
  Far side: a three-tap delay line fed by the encoded pulse, and a drive
  that counts the flux pulses it receives.
  Assumes the bench clock; taps are one clock apart.
*/
`timescale 1ns/100ps
module dws_drive_model (
  input  wire logic clock,
  input  wire logic pulse_in,
  input  wire logic precomp_in,
  output logic      tap1,
  output logic      tap2,
  output logic      tap3,
  output int        rx_count
);
  logic [2:0] line_reg = 3'h0;
  int         count_reg = 0;

  // Equal tap spacing lets the bench tell the taps apart by latency.
  always @(posedge clock) begin
    line_reg <= {line_reg[1:0], pulse_in};
    if (precomp_in === 1'b1) count_reg <= count_reg + 1;
  end

  assign tap1 = line_reg[0];
  assign tap2 = line_reg[1];
  assign tap3 = line_reg[2];
  assign rx_count = count_reg;
endmodule

/* sim/disk_write_serializer_mfm_bench.sv */
/*
  Bench for the write serializer: frames of sync zeros, mark, random data
  and appended check bits in both check modes and both drive speeds.
  Assumes the drive model echoes each encoded pulse on three taps.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module disk_write_serializer_mfm_bench
  import dws_pkg::*;
;
  logic       clock = 1'b0;
  logic       rst_b = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] io_data = 8'h00;
  logic       byte_load_strobe = 1'b0;
  logic       write_enable_n = 1'b1;
  logic       check_init_n = 1'b1;
  logic       check_append_lookahead_n = 1'b1;
  logic       precomp_enable = 1'b0;
  logic       wc_d = 1'b0;
  logic       cap = 1'b0;
  logic       pc_seen = 1'b0;
  logic [7:0] reg_rdata, rd_val;
  logic       delay_tap1, delay_tap2, delay_tap3, write_clock, nrz_data, byte_slot_flag;
  logic       byte_time_sync, encoded_write_out, precomp_early, precomp_nominal;
  logic       precomp_late, precomp_write_out, irq;
  logic       bits_q[$];
  int         mismatches = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  int         t_enc = 0;
  int         de = -1;
  int         dn = -1;
  int         dl = -1;
  int         rx_count;
  int         seed = 32'hb7e4e4e2;

  dws_top i_dut (.clock(clock), .rst_b(rst_b), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .io_data(io_data), .byte_load_strobe(byte_load_strobe), .write_enable_n(write_enable_n),
    .check_init_n(check_init_n), .check_append_lookahead_n(check_append_lookahead_n),
    .precomp_enable(precomp_enable), .delay_tap1(delay_tap1), .delay_tap2(delay_tap2),
    .delay_tap3(delay_tap3), .write_clock(write_clock), .nrz_data(nrz_data),
    .byte_slot_flag(byte_slot_flag), .byte_time_sync(byte_time_sync),
    .encoded_write_out(encoded_write_out), .precomp_early(precomp_early),
    .precomp_nominal(precomp_nominal), .precomp_late(precomp_late),
    .precomp_write_out(precomp_write_out), .irq(irq));

  dws_drive_model i_drive (.clock(clock), .pulse_in(encoded_write_out),
    .precomp_in(precomp_write_out), .tap1(delay_tap1), .tap2(delay_tap2),
    .tap3(delay_tap3), .rx_count(rx_count));

  always #12.5 clock = ~clock;

  // Sample NRZ mid-bit, time each tap pulse, and cut a hang short.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    wc_d <= write_clock;
    if (cap && wc_d === 1'b1 && write_clock === 1'b0) bits_q.push_back(nrz_data);
    if (encoded_write_out === 1'b1) t_enc = cyc;
    if (precomp_early === 1'b1 || precomp_late === 1'b1) pc_seen = 1'b1;
    if (precomp_write_out === 1'b1) begin
      if (precomp_early === 1'b1) de = cyc - t_enc;
      if (precomp_nominal === 1'b1) dn = cyc - t_enc;
      if (precomp_late === 1'b1) dl = cyc - t_enc;
    end
    if (cyc == 20000) begin
      mismatches++;
      final_report();
    end
  end

  // One division step, MSB-first feedback as in the check generator.
  function automatic logic [31:0] chk_step(input logic [31:0] c, input logic b, input logic ecc);
    logic fb;
    fb = b ^ (ecc ? c[31] : c[15]);
    c = c << 1;
    if (fb) c = c ^ (ecc ? ECC_MASK : CRC_MASK);
    return ecc ? c : (c & CRC_KEEP);
  endfunction

  task automatic final_report();
    if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe.
  task automatic reg_read(input logic [1:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    rd_val = reg_rdata;
  endtask

  task automatic wait_sync();
    @(posedge clock);
    while (byte_time_sync !== 1'b1) @(posedge clock);
  endtask

  // Data held well past the strobe's trailing edge, as the sync needs.
  task automatic load(input logic [7:0] d);
    @(posedge clock);
    io_data <= d;
    byte_load_strobe <= 1'b1;
    repeat (4) @(posedge clock);
    byte_load_strobe <= 1'b0;
    repeat (6) @(posedge clock);
    `CHK(byte_slot_flag, 1'b0)
  endtask

  task automatic run_frame(input logic ecc, input logic slow, input logic pc);
    logic [7:0]  exp_q[$];
    logic [7:0]  d;
    logic [31:0] crc;
    logic        eb;
    int          n;
    int          w;
    exp_q = {8'ha1};
    crc = CHK_PRESET;
    w = ecc ? 32 : 16;
    reg_write(ADDR_CTRL, {6'h00, slow, ecc});
    @(posedge clock);
    precomp_enable <= pc;
    write_enable_n <= 1'b0;
    wait_sync();
    load(8'h00);
    pc_seen = 1'b0;
    repeat (2) wait_sync();
    check_init_n <= 1'b0;
    repeat (12) @(posedge clock);
    check_init_n <= 1'b1;
    cap = 1'b1;
    bits_q = {};
    repeat (2) wait_sync();
    load(8'ha1);
    for (int k = 0; k < 4; k++) begin
      wait_sync();
      d = (k == 2) ? exp_q[$] : 8'($random(seed));
      if (k != 2) load(d);
      exp_q.push_back(d);
    end
    check_append_lookahead_n <= 1'b0;
    repeat (8) wait_sync();
    check_append_lookahead_n <= 1'b1;
    write_enable_n <= 1'b1;
    cap = 1'b0;
    foreach (exp_q[i]) for (int b = 7; b >= 0; b--) crc = chk_step(crc, exp_q[i][b], ecc);
    n = 0;
    while (n < bits_q.size() && bits_q[n] !== 1'b1) n++;
    for (int k = 0; k < 56 + w; k++) begin
      if (k < 40) eb = exp_q[k / 8][7 - k % 8];
      else if (k < 40 + w) eb = crc[w - 1 - (k - 40)];
      else eb = 1'b0;
      `CHK(bits_q[n + k], eb)
    end
    `CHK(pc_seen, pc)
  endtask

  // Reset, register defaults, four frames with the interrupt path after the first, then tap timing.
  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    reg_read(ADDR_MASK);
    `CHK(rd_val, {5'h00, MASK_RESET})
    reg_read(ADDR_CTRL);
    `CHK(rd_val, {6'h00, CTRL_RESET})
    reg_write(2'h3, 8'hff);
    reg_read(2'h3);
    `CHK(rd_val, 8'h00)
    reg_read(ADDR_MASK);
    `CHK(rd_val, 8'h00)
    for (int m = 0; m < 4; m++) begin
      run_frame(m[0], m[1], m[0] ^ m[1]);
      if (m == 0) begin
        reg_read(ADDR_STATUS);
        `CHK(rd_val[2:0], 3'h7)
        `CHK(irq, 1'b0)
        reg_write(ADDR_MASK, 8'h04);
        repeat (3) @(posedge clock);
        `CHK(irq, 1'b1)
        reg_write(ADDR_STATUS, 8'h04);
        repeat (3) @(posedge clock);
        `CHK(irq, 1'b0)
        reg_read(ADDR_STATUS);
        `CHK(rd_val[2:0], 3'h3)
        reg_write(ADDR_STATUS, 8'h03);
        reg_read(ADDR_STATUS);
        `CHK(rd_val[2:0], 3'h0)
      end
    end
    `CHK(de + 1, dn)
    `CHK(dn + 1, dl)
    `CHK(rx_count > 0, 1'b1)
    final_report();
  end
endmodule
